// file: spi_port_regs.svh
// Register indices, field positions, reset values and divider counts of the SPI port.
// Included by the port module; holds definitions only.
`ifndef SPI_PORT_REGS_SVH
`define SPI_PORT_REGS_SVH

// Register indices; byte address is four times the index
`define SPI_IDX_STATUS_CONTROL 2'h0
`define SPI_IDX_FRAME_SIZE     2'h1
`define SPI_IDX_DATA           2'h2

// Status/control field positions
`define SPI_BIT_ORDER    14
`define SPI_BIT_RX_FULL  13
`define SPI_BIT_ERR_IE   12
`define SPI_BIT_OVERRUN  11
`define SPI_BIT_SFAULT   10
`define SPI_BIT_TX_EMPTY 9
`define SPI_BIT_SF_EN    8
`define SPI_BIT_RATE_HI  7
`define SPI_BIT_RATE_LO  6
`define SPI_BIT_RX_IE    5
`define SPI_BIT_MASTER   4
`define SPI_BIT_CLOCK_IDLE_LEVEL     3
`define SPI_BIT_CLOCK_PHASE_SEL     2
`define SPI_BIT_ENABLE   1
`define SPI_BIT_TX_IE    0

// Reset values
`define SPI_STATUS_CONTROL_RESET 16'h0000
`define SPI_FRAME_SIZE_RESET     4'h0
`define SPI_DATA_RESET           16'h0000

// Half serial-clock periods in module clocks for divisors 2, 8, 16, 32
`define SPI_HALF_DIV2  5'h01
`define SPI_HALF_DIV8  5'h04
`define SPI_HALF_DIV16 5'h08
`define SPI_HALF_DIV32 5'h10

`endif

// file: spi_port_pkg.sv
// Types shared by the SPI port: transfer state and the packed state record.
// Assumes the constants header supplies all numeric values.
package spi_port_pkg;

  typedef enum logic [0:0] {
    XFER_IDLE  = 1'b0,
    XFER_SHIFT = 1'b1
  } xfer_t;

  typedef struct packed {
    xfer_t       st;
    logic        bit_order_sel;
    logic        error_irq_en;
    logic        select_fault_en;
    logic [1:0]  rate_sel;
    logic        rx_irq_en;
    logic        master_sel;
    logic        clock_idle_level;
    logic        clock_phase_sel;
    logic        port_enable;
    logic        tx_irq_en;
    logic        rx_full_flag;
    logic        overrun_flag;
    logic        select_fault_flag;
    logic        tx_empty_flag;
    logic        ovr_armed;
    logic [3:0]  frame_len_code;
    logic [3:0]  frame_len_latched;
    logic [15:0] rx_data;
    logic [15:0] tx_data;
    logic [15:0] sh_tx;
    logic [15:0] sh_rx;
    logic [4:0]  bit_cnt;
    logic [4:0]  half_cnt;
    logic        sclk_out;
    logic        dout;
    logic        sclk_prev;
    logic        ss_prev;
    logic [31:0] rdata;
  } port_state_t;

endpackage

// file: spi_master_slave_port.sv
// SPI port able to act as master or slave, with APB register access.
// Assumes serial pins are synchronous to i_clk_sys; pin wires are resolved outside.
`include "spi_port_regs.svh"

// Overview of operation
// - Bit 14 picks LSB-first when set; parallel data right-justified, upper bits zero.
// - Receive-full sets when a word enters receive register, clears on its read.
// - Error enable lets overrun, and enabled select fault, drive error request.
// - Word completing while previous unread sets overrun; old word kept, new dropped.
// - Overrun clears by status read while set, then receive data read.
// - Select fault: slave select rising mid-transfer, or master select low.
// - Writing one to the select fault bit clears it when select is high or slave role is written.
// - Transmit-empty sets on load into shifter, clears on transmit data write.
// - Fault enable permits setting and gates the flag's error request; low means master ignores select.
// - Master rate field divides module clock by 2, 8, 16 or 32.
// - Receive interrupt follows receive-full and its enable, regardless of port enable.
// - Bit 4 selects slave when zero, master when one.
// - Bit 3 sets serial clock idle level; both ends share polarity and phase.
// - Transmit interrupt needs enable, transmit-empty and port enable.
// - Disabled port sets transmit-empty, aborts slave, finishes master, clears counter.
// - Data registers, control bits and sticky flags survive disable; only reset clears.
// - Size code plus one gives frame length 1 to 16 bits.
// - New size applies only when port enable rises.
// - Without new transmit data master waits, slave resends previous word.
// - Master select fault clears port enable.
// - Unimplemented register bits read zero and ignore writes.
// - Deselected slave floats its serial output and ignores clock edges.
// - Slave transfer starts on select fall or first clock edge; ends at idle.
// - Master select fault stays set until select high or slave role.
module spi_master_slave_port #(
  parameter int ADDR_W = 4
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rstn,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  output logic [31:0]            o_prdata,
  input  wire logic              i_sclk,
  output logic                   o_sclk_o,
  output logic                   o_sclk_oe,
  input  wire logic              i_mosi,
  output logic                   o_mosi_o,
  output logic                   o_mosi_oe,
  input  wire logic              i_miso,
  output logic                   o_miso_o,
  output logic                   o_miso_oe,
  input  wire logic              i_ss_n,
  output logic                   o_irq_tx,
  output logic                   o_irq_rx,
  output logic                   o_irq_err
);

  spi_port_pkg::port_state_t s_r;
  spi_port_pkg::port_state_t s_nxt;

  logic [1:0]  reg_idx;
  logic        acc;
  logic        wr_status;
  logic        wr_size;
  logic        wr_tx;
  logic        rd_status;
  logic        rd_rx;
  logic [4:0]  frame_len;
  logic [4:0]  half_len;
  logic        m_tick;
  logic        s_act;
  logic        lead_ev;
  logic        trail_ev;
  logic        m_start;
  logic        s_start;
  logic        din;
  logic        complete;
  logic        m_fault;
  logic [15:0] src;
  logic [15:0] rx_new;

  function automatic logic [3:0] bit_idx(input logic [4:0] cnt, input logic [4:0] len,
                                         input logic lsb);
    logic [4:0] r;
    r = lsb ? cnt : (len - 5'd1 - cnt);
    return r[3:0];
  endfunction

  function automatic logic [4:0] half_of(input logic [1:0] rate);
    logic [4:0] h;
    case (rate)
      2'b00:   h = `SPI_HALF_DIV2;
      2'b01:   h = `SPI_HALF_DIV8;
      2'b10:   h = `SPI_HALF_DIV16;
      2'b11:   h = `SPI_HALF_DIV32;
      default: h = `SPI_HALF_DIV2;
    endcase
    return h;
  endfunction

  function automatic logic [15:0] status_word(input spi_port_pkg::port_state_t s);
    logic [15:0] w;
    w = 16'h0000;
    w[`SPI_BIT_ORDER]    = s.bit_order_sel;
    w[`SPI_BIT_RX_FULL]  = s.rx_full_flag;
    w[`SPI_BIT_ERR_IE]   = s.error_irq_en;
    w[`SPI_BIT_OVERRUN]  = s.overrun_flag;
    w[`SPI_BIT_SFAULT]   = s.select_fault_flag;
    w[`SPI_BIT_TX_EMPTY] = s.tx_empty_flag;
    w[`SPI_BIT_SF_EN]    = s.select_fault_en;
    w[`SPI_BIT_RATE_HI]  = s.rate_sel[1];
    w[`SPI_BIT_RATE_LO]  = s.rate_sel[0];
    w[`SPI_BIT_RX_IE]    = s.rx_irq_en;
    w[`SPI_BIT_MASTER]   = s.master_sel;
    w[`SPI_BIT_CLOCK_IDLE_LEVEL]     = s.clock_idle_level;
    w[`SPI_BIT_CLOCK_PHASE_SEL]     = s.clock_phase_sel;
    w[`SPI_BIT_ENABLE]   = s.port_enable;
    w[`SPI_BIT_TX_IE]    = s.tx_irq_en;
    return w;
  endfunction

  // Zero-wait slave: read data is captured in the setup cycle
  assign reg_idx   = i_paddr[3:2];
  assign acc       = i_psel & i_penable;
  assign o_pready  = 1'b1;
  assign o_pslverr = acc & (reg_idx == 2'h3);
  assign o_prdata  = s_r.rdata;
  assign wr_status = acc & i_pwrite & (reg_idx == `SPI_IDX_STATUS_CONTROL);
  assign wr_size   = acc & i_pwrite & (reg_idx == `SPI_IDX_FRAME_SIZE);
  assign wr_tx     = acc & i_pwrite & (reg_idx == `SPI_IDX_DATA);
  assign rd_status = acc & ~i_pwrite & (reg_idx == `SPI_IDX_STATUS_CONTROL);
  assign rd_rx     = acc & ~i_pwrite & (reg_idx == `SPI_IDX_DATA);

  assign frame_len = {1'b0, s_r.frame_len_latched} + 5'd1;
  assign half_len  = half_of(s_r.rate_sel);
  assign m_tick    = s_r.master_sel & (s_r.st == spi_port_pkg::XFER_SHIFT) &
                     (s_r.half_cnt == half_len - 5'd1);
  // Deselected or disabled slave sees no clock edges
  assign s_act     = ~s_r.master_sel & s_r.port_enable & ~i_ss_n;
  assign lead_ev   = s_r.master_sel ? (m_tick & (s_r.sclk_out == s_r.clock_idle_level)) :
                     (s_act & (s_r.sclk_prev == s_r.clock_idle_level) &
                      (i_sclk != s_r.clock_idle_level));
  assign trail_ev  = s_r.master_sel ? (m_tick & (s_r.sclk_out != s_r.clock_idle_level)) :
                     (s_act & (s_r.sclk_prev != s_r.clock_idle_level) &
                      (i_sclk == s_r.clock_idle_level));
  // Master waits for fresh data; slave reloads whatever is held
  assign m_start   = s_r.master_sel & s_r.port_enable & ~s_r.tx_empty_flag &
                     (s_r.st == spi_port_pkg::XFER_IDLE) & ~m_fault;
  assign s_start   = ~s_r.master_sel & s_r.port_enable & (s_r.st == spi_port_pkg::XFER_IDLE) &
                     (s_r.clock_phase_sel ? (lead_ev & ~i_ss_n) : (s_r.ss_prev & ~i_ss_n));
  assign m_fault   = s_r.master_sel & s_r.port_enable & s_r.select_fault_en & ~i_ss_n;
  assign din       = s_r.master_sel ? i_miso : i_mosi;
  assign src       = s_start ? s_r.tx_data : s_r.sh_tx;

  always_comb begin
    rx_new = s_r.sh_rx;
    if ((lead_ev & ~s_r.clock_phase_sel) | (trail_ev & s_r.clock_phase_sel)) begin
      rx_new[bit_idx(s_r.bit_cnt, frame_len, s_r.bit_order_sel)] = din;
    end
  end

  assign complete = (s_r.st == spi_port_pkg::XFER_SHIFT) & trail_ev & ~m_fault &
                    (s_r.bit_cnt == frame_len - 5'd1);

  always_comb begin
    s_nxt = s_r;
    s_nxt.sclk_prev = i_sclk;
    s_nxt.ss_prev   = i_ss_n;
    // Register bus: capture read data at setup, side effects at access
    if (i_psel & ~i_penable & ~i_pwrite) begin
      case (reg_idx)
        `SPI_IDX_STATUS_CONTROL: s_nxt.rdata = {16'h0000, status_word(s_r)};
        `SPI_IDX_FRAME_SIZE:     s_nxt.rdata = {28'h0000000, s_r.frame_len_code};
        `SPI_IDX_DATA:           s_nxt.rdata = {16'h0000, s_r.rx_data};
        default:                 s_nxt.rdata = 32'h00000000;
      endcase
    end
    if (wr_status) begin
      s_nxt.bit_order_sel    = i_pwdata[`SPI_BIT_ORDER];
      s_nxt.error_irq_en     = i_pwdata[`SPI_BIT_ERR_IE];
      s_nxt.select_fault_en  = i_pwdata[`SPI_BIT_SF_EN];
      s_nxt.rate_sel         = i_pwdata[`SPI_BIT_RATE_HI:`SPI_BIT_RATE_LO];
      s_nxt.rx_irq_en        = i_pwdata[`SPI_BIT_RX_IE];
      s_nxt.master_sel       = i_pwdata[`SPI_BIT_MASTER];
      s_nxt.clock_idle_level = i_pwdata[`SPI_BIT_CLOCK_IDLE_LEVEL];
      s_nxt.clock_phase_sel  = i_pwdata[`SPI_BIT_CLOCK_PHASE_SEL];
      s_nxt.port_enable      = i_pwdata[`SPI_BIT_ENABLE];
      s_nxt.tx_irq_en        = i_pwdata[`SPI_BIT_TX_IE];
      if (i_pwdata[`SPI_BIT_ENABLE] & ~s_r.port_enable) begin
        s_nxt.frame_len_latched = s_r.frame_len_code;
      end
      // Master fault holds while select is low in master role
      if (i_pwdata[`SPI_BIT_SFAULT] & (i_ss_n | ~i_pwdata[`SPI_BIT_MASTER])) begin
        s_nxt.select_fault_flag = 1'b0;
      end
    end
    if (wr_size) begin
      s_nxt.frame_len_code = i_pwdata[3:0];
    end
    if (wr_tx) begin
      s_nxt.tx_data       = i_pwdata[15:0];
      s_nxt.tx_empty_flag = 1'b0;
    end
    if (rd_status & s_r.overrun_flag) begin
      s_nxt.ovr_armed = 1'b1;
    end
    if (rd_rx) begin
      s_nxt.rx_full_flag = 1'b0;
      if (s_r.ovr_armed) begin
        s_nxt.overrun_flag = 1'b0;
        s_nxt.ovr_armed    = 1'b0;
      end
    end
    // Serial engine
    if (m_start | s_start) begin
      s_nxt.st            = spi_port_pkg::XFER_SHIFT;
      s_nxt.sh_tx         = s_r.tx_data;
      s_nxt.sh_rx         = 16'h0000;
      s_nxt.tx_empty_flag = 1'b1;
      s_nxt.bit_cnt       = 5'd0;
      s_nxt.half_cnt      = 5'd0;
      if (~s_r.clock_phase_sel) begin
        s_nxt.dout = s_r.tx_data[bit_idx(5'd0, frame_len, s_r.bit_order_sel)];
      end
    end
    if (s_r.st == spi_port_pkg::XFER_SHIFT || s_start) begin
      if (s_r.master_sel) begin
        s_nxt.half_cnt = m_tick ? 5'd0 : s_r.half_cnt + 5'd1;
        if (m_tick) begin
          s_nxt.sclk_out = ~s_r.sclk_out;
        end
      end
      if (s_start) begin
        s_nxt.sh_rx = 16'h0000;
      end else begin
        s_nxt.sh_rx = rx_new;
      end
      if (lead_ev & s_r.clock_phase_sel) begin
        s_nxt.dout = src[bit_idx(s_r.bit_cnt, frame_len, s_r.bit_order_sel)];
        if (s_start) begin
          s_nxt.sh_rx = 16'h0000;
        end
      end
      if (trail_ev) begin
        if (complete) begin
          s_nxt.st      = spi_port_pkg::XFER_IDLE;
          s_nxt.bit_cnt = 5'd0;
          if (s_r.rx_full_flag | s_r.overrun_flag) begin
            s_nxt.overrun_flag = 1'b1;
          end else begin
            s_nxt.rx_data      = rx_new;
            s_nxt.rx_full_flag = 1'b1;
          end
        end else begin
          s_nxt.bit_cnt = s_r.bit_cnt + 5'd1;
          if (~s_r.clock_phase_sel) begin
            s_nxt.dout = s_r.sh_tx[bit_idx(s_r.bit_cnt + 5'd1, frame_len, s_r.bit_order_sel)];
          end
        end
      end
    end
    if (s_r.st == spi_port_pkg::XFER_IDLE) begin
      s_nxt.sclk_out = s_r.clock_idle_level;
    end
    // Slave abort on deselect or disable; the word in flight is lost
    if (~s_r.master_sel & (s_r.st == spi_port_pkg::XFER_SHIFT) & (i_ss_n | ~s_r.port_enable)) begin
      s_nxt.st      = spi_port_pkg::XFER_IDLE;
      s_nxt.bit_cnt = 5'd0;
      if (i_ss_n & s_r.port_enable & s_r.select_fault_en) begin
        s_nxt.select_fault_flag = 1'b1;
      end
    end
    // Master fault stops driving at once to avoid contention
    if (m_fault) begin
      s_nxt.select_fault_flag = 1'b1;
      s_nxt.port_enable       = 1'b0;
      s_nxt.st                = spi_port_pkg::XFER_IDLE;
      s_nxt.bit_cnt           = 5'd0;
      s_nxt.sclk_out          = s_r.clock_idle_level;
    end
    // Partial reset leaves data, control and sticky flags alone
    if (~s_r.port_enable) begin
      s_nxt.tx_empty_flag = 1'b1;
      if (~(s_r.master_sel & (s_r.st == spi_port_pkg::XFER_SHIFT))) begin
        s_nxt.bit_cnt  = 5'd0;
        s_nxt.half_cnt = 5'd0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r         <= '0;
      s_r.tx_data <= `SPI_DATA_RESET;
      s_r.rx_data <= `SPI_DATA_RESET;
      s_r.ss_prev <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Master keeps driving a transfer that outlives its enable
  assign o_sclk_o  = s_r.sclk_out;
  assign o_mosi_o  = s_r.dout;
  assign o_miso_o  = s_r.dout;
  assign o_sclk_oe = s_r.master_sel & (s_r.port_enable | (s_r.st == spi_port_pkg::XFER_SHIFT));
  assign o_mosi_oe = o_sclk_oe;
  assign o_miso_oe = ~s_r.master_sel & s_r.port_enable & ~i_ss_n;

  // Level requests
  assign o_irq_tx  = s_r.tx_irq_en & s_r.port_enable & s_r.tx_empty_flag;
  assign o_irq_rx  = s_r.rx_irq_en & s_r.rx_full_flag;
  assign o_irq_err = s_r.error_irq_en &
                     (s_r.overrun_flag | (s_r.select_fault_flag & s_r.select_fault_en));

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  a_rx_full_set: assert property (complete && !s_r.rx_full_flag && !s_r.overrun_flag
    |=> s_r.rx_full_flag && s_r.rx_data == $past(rx_new))
    else $error("receive word not stored");
  a_rx_full_clr: assert property (rd_rx && !complete |=> !s_r.rx_full_flag)
    else $error("receive-full not cleared by read");
  a_overrun_keep: assert property (complete && s_r.rx_full_flag
    |=> s_r.overrun_flag && $stable(s_r.rx_data))
    else $error("overrun did not keep old word");
  a_master_fault: assert property (m_fault |=> s_r.select_fault_flag && !s_r.port_enable)
    else $error("master fault did not disable port");
  a_tx_write_clr: assert property (wr_tx && !m_start && !s_start && s_r.port_enable
    |=> !s_r.tx_empty_flag)
    else $error("transmit-empty not cleared by write");
  a_tx_irq_gate: assert property (!s_r.port_enable |-> !o_irq_tx)
    else $error("transmit request while disabled");
  a_size_latch: assert property ($rose(s_r.port_enable)
    |-> s_r.frame_len_latched == $past(s_r.frame_len_code))
    else $error("frame size not latched on enable");
  a_miso_float: assert property (i_ss_n |-> !o_miso_oe)
    else $error("deselected slave drives output");
  a_rate_div2: assert property (s_r.master_sel && s_r.st == spi_port_pkg::XFER_SHIFT &&
    s_r.rate_sel == 2'b00 && s_nxt.st == spi_port_pkg::XFER_SHIFT && !m_fault
    |=> $changed(s_r.sclk_out))
    else $error("divide-by-two clock did not toggle");
  a_disable_txe: assert property (!s_r.port_enable |=> s_r.tx_empty_flag)
    else $error("disabled port not transmit-empty");
  a_rsvd_zero: assert property (o_prdata[31:16] == 16'h0000)
    else $error("upper read half nonzero");
  a_rsvd_status: assert property (i_psel && !i_penable && !i_pwrite && reg_idx == 2'h0
    |=> !o_prdata[15])
    else $error("status bit 15 reads nonzero");
  a_rsvd_size: assert property (i_psel && !i_penable && !i_pwrite && reg_idx == 2'h1
    |=> o_prdata[15:4] == 12'h000)
    else $error("size upper bits read nonzero");
  a_master_wait: assert property (s_r.master_sel && s_r.tx_empty_flag &&
    s_r.st == spi_port_pkg::XFER_IDLE |=> s_r.st == spi_port_pkg::XFER_IDLE)
    else $error("master started without fresh data");
  a_fault_gate: assert property (!s_r.select_fault_en && !s_r.select_fault_flag |=> !s_r.select_fault_flag)
    else $error("select fault set while disabled");
  a_slave_start: assert property (s_start |=> s_r.st == spi_port_pkg::XFER_SHIFT)
    else $error("slave transfer did not start");
  a_rx_irq: assert property (s_r.rx_irq_en && s_r.rx_full_flag |-> o_irq_rx)
    else $error("receive request missing");

  c_master_done: cover property (complete && s_r.master_sel);
  c_slave_done: cover property (complete && !s_r.master_sel);
  c_overrun: cover property (complete && s_r.rx_full_flag);
  c_fault: cover property (m_fault);
  c_phase1_start: cover property (s_start && s_r.clock_phase_sel);

endmodule

// file: spi_far_model.sv
// Behavioural far-side SPI slave for the port in master role, 8-bit frames, phase 0.
// Assumes the tb pulses i_load with the word to return before each frame.
module spi_far_model (
  input  wire logic       i_sclk,
  input  wire logic       i_mosi,
  input  wire logic       i_clock_idle_level,
  input  wire logic       i_load,
  input  wire logic [7:0] i_word,
  output logic            o_miso,
  output logic [7:0]      o_rx
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sh;
  logic [3:0] left;
  logic       last;
  initial begin
    sh = 8'h00;
    left = 4'h0;
    last = 1'b0;
    o_rx = 8'h00;
  end
  always @(posedge i_load) begin
    sh = i_word;
    left = 4'h8;
  end
  // Same polarity and phase as the port: sample on leading, shift on trailing
  always @(i_sclk) begin
    if (left != 4'h0) begin
      if (i_sclk !== i_clock_idle_level) o_rx = {o_rx[6:0], i_mosi};
      else begin
        last = sh[7];
        sh = {sh[6:0], 1'b0};
        left = left - 4'h1;
      end
    end
  end
  // Released line shows the inverse of its last bit, so a late sample cannot pass
  assign o_miso = (left != 4'h0) ? sh[7] : ~last;
endmodule

// file: tb.sv
// Self-checking bench: APB master, far-side slave model, read-result queue.
// Assumes it drives every port input; in slave role the bench itself is the far master.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rstn, psel, penable, pwrite, ss_n, load, pready, pslverr;
  logic [3:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        sclk, sclk_oe, mosi, miso, irq_tx, irq_rx, irq_err;
  logic        ssclk, smosi, smiso, miso_oe;
  logic [7:0]  pword, prx, pw, tw, sg;
  logic [16:0] exp_q[$], msk_q[$];
  logic [4:0]  hcnt, hlen;
  int          failures, n_checks, seed, r;
  int          half[4] = '{1, 4, 8, 16};

  spi_far_model far (.i_sclk(sclk), .i_mosi(mosi), .i_clock_idle_level(1'b0), .i_load(load),
    .i_word(pword), .o_miso(miso), .o_rx(prx));
  spi_master_slave_port #(.ADDR_W(4)) dut (.i_clk_sys(clk), .i_rstn(rstn), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata), .i_sclk(ssclk),
    .o_sclk_o(sclk), .o_sclk_oe(sclk_oe), .i_mosi(smosi), .o_mosi_o(mosi), .o_mosi_oe(),
    .i_miso(miso), .o_miso_o(smiso), .o_miso_oe(miso_oe), .i_ss_n(ss_n), .o_irq_tx(irq_tx),
    .o_irq_rx(irq_rx), .o_irq_err(irq_err));

  always #25 clk = ~clk;

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One APB transfer; a read notes {pslverr, data} with a mask for the watcher
  task automatic apb(input logic wr, input logic [1:0] idx, input logic [15:0] d,
                     input logic [16:0] e, input logic [16:0] m);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    if (!wr) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      failures++;
      final_report();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_irq(input int which);
    int n;
    for (n = 0; n < 4000; n++) begin
      @(negedge clk);
      if ((which == 0 ? irq_rx : irq_err) === 1'b1) break;
    end
    if (n == 4000) begin
      failures++;
      final_report();
    end
  endtask

  task automatic xfer(input logic [7:0] p, input logic [7:0] t);
    @(posedge clk);
    pword <= p;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    apb(1'b1, 2'h2, {8'h00, t}, 17'h0, 17'h0);
  endtask

  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[7-i];
  endfunction

  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      chk({pslverr, prdata[15:0]} & msk_q[0], exp_q[0] & msk_q[0]);
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  always @(posedge clk) begin
    if (sclk === 1'b1) hcnt <= hcnt + 5'h01;
    else begin
      if (hcnt != 5'h00) hlen <= hcnt;
      hcnt <= 5'h00;
    end
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {psel, penable, pwrite, load} = 4'h0;
    ss_n = 1'b1; // Select stays high between frames
    paddr = 4'h0;
    pwdata = 32'h0;
    pword = 8'h00;
    ssclk = 1'b1;
    smosi = 1'b0;
    sg = 8'h00;
    hcnt = 5'h00;
    hlen = 5'h00;
    seed = 90016;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, 2'h0, 16'h0, 17'h00200, 17'h1ffff);
    apb(1'b0, 2'h3, 16'h0, 17'h10000, 17'h1ffff); // Unmapped index refused
    apb(1'b1, 2'h1, 16'hffff, 17'h0, 17'h0);
    apb(1'b0, 2'h1, 16'h0, 17'h0000f, 17'h1ffff);
    apb(1'b1, 2'h0, 16'h8000, 17'h0, 17'h0);
    apb(1'b0, 2'h0, 16'h0, 17'h00000, 17'h08000);
    apb(1'b1, 2'h1, 16'h0007, 17'h0, 17'h0);
    $display("test registers done");
    // Every rate code, bit order alternating; size latched on first enable
    for (r = 0; r < 4; r++) begin
      apb(1'b1, 2'h0, 16'(32'h0032 | (r << 6) | (r[0] << 14)), 17'h0, 17'h0);
      pw = 8'($random(seed));
      tw = 8'($random(seed));
      xfer(pw, tw);
      wait_irq(0);
      chk({16'h0, sclk_oe}, 17'h1);
      chk({12'h0, hlen}, 17'(half[r]));
      chk({9'h0, prx}, {9'h0, r[0] ? rev8(tw) : tw});
      apb(1'b0, 2'h2, 16'h0, {9'h0, r[0] ? rev8(pw) : pw}, 17'h1ffff);
      @(negedge clk);
      chk({16'h0, irq_rx}, 17'h0);
    end
    $display("test transfers done");
    apb(1'b1, 2'h0, 16'h1032, 17'h0, 17'h0);
    pw = 8'($random(seed));
    xfer(pw, 8'h3c);
    wait_irq(0);
    xfer(~pw, 8'hc3);
    wait_irq(1);
    apb(1'b0, 2'h0, 16'h0, 17'h02800, 17'h02800);
    apb(1'b0, 2'h2, 16'h0, {9'h0, pw}, 17'h1ffff);
    apb(1'b0, 2'h0, 16'h0, 17'h00000, 17'h02800);
    @(negedge clk);
    chk({16'h0, irq_err}, 17'h0);
    $display("test overrun done");
    apb(1'b1, 2'h0, 16'h1132, 17'h0, 17'h0);
    @(posedge clk);
    ss_n <= 1'b0;
    repeat (3) @(posedge clk);
    apb(1'b0, 2'h0, 16'h0, 17'h00400, 17'h00402);
    @(negedge clk);
    chk({16'h0, irq_err}, 17'h1);
    apb(1'b1, 2'h0, 16'h0510, 17'h0, 17'h0);
    apb(1'b0, 2'h0, 16'h0, 17'h00400, 17'h00400);
    @(posedge clk);
    ss_n <= 1'b1;
    apb(1'b1, 2'h0, 16'h0400, 17'h0, 17'h0);
    apb(1'b0, 2'h0, 16'h0, 17'h00000, 17'h00400);
    $display("test fault done");
    apb(1'b1, 2'h0, 16'h0001, 17'h0, 17'h0);
    @(negedge clk);
    chk({16'h0, irq_tx}, 17'h0);
    apb(1'b0, 2'h2, 16'h0, {9'h0, pw}, 17'h1ffff);
    apb(1'b1, 2'h0, 16'h0013, 17'h0, 17'h0);
    @(negedge clk);
    chk({16'h0, irq_tx}, 17'h1);
    $display("test transmit request done");
    // Bench as far master, polarity 1, phase 1; second frame reuses the held word
    apb(1'b1, 2'h0, 16'h002e, 17'h0, 17'h0);
    @(negedge clk);
    chk({16'h0, sclk_oe}, 17'h0);
    tw = 8'($random(seed));
    apb(1'b1, 2'h2, {8'h00, tw}, 17'h0, 17'h0);
    for (r = 0; r < 2; r++) begin
      pw = 8'($random(seed));
      ss_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk({16'h0, miso_oe}, 17'h1);
      for (int b = 7; b >= 0; b--) begin
        ssclk <= 1'b0;
        smosi <= pw[b];
        repeat (4) @(posedge clk);
        sg = {sg[6:0], smiso};
        ssclk <= 1'b1;
        repeat (4) @(posedge clk);
      end
      ss_n <= 1'b1;
      chk({9'h0, sg}, {9'h0, tw});
      apb(1'b0, 2'h2, 16'h0, {9'h0, pw}, 17'h1ffff);
    end
    chk({16'h0, miso_oe}, 17'h0);
    $display("test slave done");
    repeat (4) @(posedge clk);
    final_report();
  end
endmodule
